/* File: hw/rie_pkg.sv */
// Shared constants, types and register map of the rotate instruction execution block.
package rie_pkg;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int RIE_FA_W = 12;                     // Data memory address width.
  localparam int RIE_BANK_W = 4;                    // Bank pointer width.
  localparam int RIE_OFS_W = 8;                     // AXI address width seen by the slave.

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] RIE_OFS_CTRL = 8'h00;      // Extended instruction set enable.
  localparam logic [7:0] RIE_OFS_BANK = 8'h04;      // Bank pointer register.
  localparam logic [7:0] RIE_OFS_WREG = 8'h08;      // Working register.
  localparam logic [7:0] RIE_OFS_STATUS = 8'h0c;    // Flags and busy state.
  localparam logic [7:0] RIE_OFS_FSR2 = 8'h10;      // Base of indexed literal offset addressing.
  localparam logic [7:0] RIE_OFS_INSTR = 8'h14;     // Writing issues one instruction word.
  localparam logic [7:0] RIE_OFS_DPTR = 8'h18;      // Data memory pointer for software access.
  localparam logic [7:0] RIE_OFS_DATA = 8'h1c;      // Data memory byte at the pointer.

  // ****************************************************************
  // Status bit positions and reset values.
  // ****************************************************************
  localparam int RIE_ST_C = 0;                      // Carry.
  localparam int RIE_ST_Z = 2;                      // Zero.
  localparam int RIE_ST_N = 4;                      // Negative.
  localparam int RIE_ST_BUSY = 8;                   // Instruction in flight.
  localparam int RIE_ST_ILL = 9;                    // Last word was not a rotate.
  localparam int RIE_CTRL_EXT = 0;                  // Extended set enable bit.
  localparam logic [7:0] RIE_BYTE_RST = 8'h00;      // Reset value of byte registers.
  localparam logic [31:0] RIE_WORD_RST = 32'h0000_0000;

  // ****************************************************************
  // Opcodes and addressing constants.
  // ****************************************************************
  localparam logic [5:0] RIE_OP_RLN = 6'h11;        // Pattern 0100 01da.
  localparam logic [5:0] RIE_OP_RRC = 6'h0c;        // Pattern 0011 00da.
  localparam logic [7:0] RIE_ILO_MAX = 8'h5f;       // Highest indexed literal offset.
  localparam logic [7:0] RIE_ACC_SPLIT = 8'h60;     // Access bank low half ends here.
  localparam logic [3:0] RIE_ACC_HI_BANK = 4'hf;    // Access bank high half lives in the top bank.
  localparam logic [1:0] RIE_RESP_OKAY = 2'b00;
  localparam logic [1:0] RIE_RESP_SLVERR = 2'b10;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    RIE_IDLE = 3'b000,
    RIE_DECODE = 3'b001,
    RIE_READ = 3'b011,
    RIE_PROCESS = 3'b010,
    RIE_WRITE = 3'b110
  } rie_state_t;

  // One instruction word split into its fields.
  typedef struct packed {
    logic [5:0] op;
    logic d;
    logic a;
    logic [7:0] f;
  } rie_instr_t;

  // One request to the data memory port.
  typedef struct packed {
    logic we;
    logic [RIE_FA_W-1:0] addr;
    logic [7:0] wdata;
  } rie_mem_req_t;

endpackage : rie_pkg

/* File: hw/rie_fregs.sv */
// Single-port data memory holding the file registers, with registered read data.
module rie_fregs
  import rie_pkg::*;
#(
  parameter int DEPTH = 4096
) (
  input wire logic aclk,
  input wire rie_mem_req_t req,
  output logic [7:0] rdata
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [7:0] mem [DEPTH];  // File register bytes, not reset.

  // Read returns the old byte on a same-cycle write, so callers see one cycle of latency always.
  always_ff @(posedge aclk) begin
    rdata <= mem[req.addr];
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

endmodule : rie_fregs

/* File: hw/rie_exec.sv */
// Rotate instruction execution datapath with an AXI4-Lite register slave.
// Overview of operation
// RL1: Rotate left plain: bit 7 wraps, N/Z only.
// RL2: Rotate right via carry: C in, bit 0 out.
// RL3: Destination bit 0 writes W, 1 the file.
// RL4: Access bit 0 selects the access bank.
// RL5: Access bit 1 uses bank pointer plus address.
// RL6: Extended set, access 0, f<=95: indexed literal offset.
// RL7: One word, one instruction cycle of four steps.
module rie_exec
  import rie_pkg::*;
#(
  parameter int DEPTH = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [RIE_OFS_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RIE_OFS_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Merge new data into an old word under the byte strobes.
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // True when the offset names a mapped register.
  function automatic logic is_mapped(input logic [RIE_OFS_W-1:0] ofs);
    return ofs == RIE_OFS_CTRL || ofs == RIE_OFS_BANK || ofs == RIE_OFS_WREG || ofs == RIE_OFS_STATUS ||
           ofs == RIE_OFS_FSR2 || ofs == RIE_OFS_INSTR || ofs == RIE_OFS_DPTR || ofs == RIE_OFS_DATA;
  endfunction : is_mapped

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  rie_state_t state;                 // Instruction sequencer.
  rie_instr_t instr;                 // Word being executed.
  logic ext_en;                      // Extended instruction set enabled.
  logic [RIE_BANK_W-1:0] bank_pointer_register;  // Selects the general purpose bank.
  logic [7:0] wreg;                  // Working register.
  logic [RIE_FA_W-1:0] fsr2;         // Index base for literal offset addressing.
  logic [RIE_FA_W-1:0] dptr;         // Software data memory pointer.
  logic flag_c;                      // Carry flag.
  logic flag_z;                      // Zero flag.
  logic flag_n;                      // Negative flag.
  logic illegal;                     // Last issued word was not a rotate.
  logic [7:0] res;                   // Rotate result held for the write step.
  logic next_c;                      // Carry produced by the rotate.
  logic [1:0] rd_stage;              // Read pipeline: 1 addresses memory, 2 captures.
  logic [RIE_OFS_W-1:0] rd_addr;     // Latched read offset.
  logic wr_en;                       // Write handshake in this cycle.
  logic rd_take;                     // Read address handshake in this cycle.
  logic [RIE_FA_W-1:0] exec_addr;    // Resolved operand address.
  logic legal;                       // Word holds a rotate opcode.
  rie_mem_req_t mem_req;             // Memory port request.
  logic [7:0] mem_rdata;             // Registered memory read data.
  logic [31:0] rd_word;              // Read mux output.

  assign wr_en = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_take = s_axi_arready && s_axi_arvalid;
  assign legal = instr.op == RIE_OP_RLN || instr.op == RIE_OP_RRC;

  // ****************************************************************
  // Operand address resolution.
  // ****************************************************************

  // Indexed literal offset wins over the access bank; the bank pointer only serves access bit 1.
  always_comb begin
    if (ext_en && !instr.a && instr.f <= RIE_ILO_MAX) begin
      exec_addr = fsr2 + {4'h0, instr.f};                    // [RL6]
    end else if (!instr.a) begin
      if (instr.f < RIE_ACC_SPLIT) begin
        exec_addr = {4'h0, instr.f};                         // [RL4]
      end else begin
        exec_addr = {RIE_ACC_HI_BANK, instr.f};              // [RL4]
      end
    end else begin
      exec_addr = {bank_pointer_register, instr.f};          // [RL5]
    end
  end

  // ****************************************************************
  // Data memory port.
  // ****************************************************************

  // Execution owns the port in its read step and, for destination 1, its write step; otherwise software reaches the pointer.
  always_comb begin
    mem_req = '{we: 1'b0, addr: dptr, wdata: s_axi_wdata[7:0]};
    if (state == RIE_READ) begin
      mem_req.addr = exec_addr;                              // [RL7]
    end else if (state == RIE_WRITE && instr.d) begin
      mem_req = '{we: 1'b1, addr: exec_addr, wdata: res};    // [RL3]
    end else if (wr_en && s_axi_awaddr == RIE_OFS_DATA && s_axi_wstrb[0]) begin
      mem_req.we = 1'b1;
    end
  end

  rie_fregs #(.DEPTH(DEPTH)) u_fregs (
    .aclk(aclk),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  // ****************************************************************
  // Instruction sequencer.
  // ****************************************************************

  // Four steps: decode, read the file, process, write the destination.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= RIE_IDLE;
    end else begin
      unique case (state)
        RIE_IDLE: begin
          if (wr_en && s_axi_awaddr == RIE_OFS_INSTR) begin
            state <= RIE_DECODE;
          end
        end
        RIE_DECODE: state <= legal ? RIE_READ : RIE_IDLE;   // [RL7]
        RIE_READ: state <= RIE_PROCESS;
        RIE_PROCESS: state <= RIE_WRITE;
        RIE_WRITE: state <= RIE_IDLE;
        default: state <= RIE_IDLE;
      endcase
    end
  end

  // Instruction word register; it only loads while idle, so fields hold steady through execution.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= '0;
    end else if (wr_en && s_axi_awaddr == RIE_OFS_INSTR) begin
      // Only the low half of the bus word holds an instruction; the upper lanes are dropped on purpose.
      instr <= rie_instr_t'(16'(strb_merge({16'h0000, instr}, s_axi_wdata, s_axi_wstrb)));
    end
  end

  // Rotate unit, evaluated in the process step on the byte just read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res <= RIE_BYTE_RST;
      next_c <= 1'b0;
    end else if (state == RIE_PROCESS) begin
      if (instr.op == RIE_OP_RLN) begin
        res <= {mem_rdata[6:0], mem_rdata[7]};               // [RL1]
        next_c <= flag_c;                                    // [RL1]
      end else begin
        res <= {flag_c, mem_rdata[7:1]};                     // [RL2]
        next_c <= mem_rdata[0];                              // [RL2]
      end
    end
  end

  // Illegal marker follows each decoded word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal <= 1'b0;
    end else if (state == RIE_DECODE) begin
      illegal <= !legal;
    end
  end

  // ****************************************************************
  // Architectural registers.
  // ****************************************************************

  // Flags: software may load them while idle; the write step updates N and Z, and C for RRC only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_c <= 1'b0;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
    end else if (state == RIE_WRITE) begin
      flag_z <= res == RIE_BYTE_RST;                         // [RL1] [RL2]
      flag_n <= res[7];                                      // [RL1] [RL2]
      if (instr.op == RIE_OP_RRC) begin
        flag_c <= next_c;                                    // [RL2]
      end
    end else if (wr_en && s_axi_awaddr == RIE_OFS_STATUS && s_axi_wstrb[0]) begin
      flag_c <= s_axi_wdata[RIE_ST_C];
      flag_z <= s_axi_wdata[RIE_ST_Z];
      flag_n <= s_axi_wdata[RIE_ST_N];
    end
  end

  // Working register: destination 0 lands here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreg <= RIE_BYTE_RST;
    end else if (state == RIE_WRITE && !instr.d) begin
      wreg <= res;                                           // [RL3]
    end else if (wr_en && s_axi_awaddr == RIE_OFS_WREG && s_axi_wstrb[0]) begin
      wreg <= s_axi_wdata[7:0];
    end
  end

  // Software-only configuration registers. Writes are taken only while idle, so an
  // instruction never sees its addressing change halfway.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en <= 1'b0;
      bank_pointer_register <= '0;
      fsr2 <= '0;
      dptr <= '0;
    end else if (wr_en) begin
      if (s_axi_awaddr == RIE_OFS_CTRL && s_axi_wstrb[0]) begin
        ext_en <= s_axi_wdata[RIE_CTRL_EXT];
      end
      if (s_axi_awaddr == RIE_OFS_BANK && s_axi_wstrb[0]) begin
        bank_pointer_register <= s_axi_wdata[RIE_BANK_W-1:0];
      end
      if (s_axi_awaddr == RIE_OFS_FSR2) begin
        // Bits above the address width are dropped on purpose.
        fsr2 <= RIE_FA_W'(strb_merge({20'h00000, fsr2}, s_axi_wdata, s_axi_wstrb));
      end
      if (s_axi_awaddr == RIE_OFS_DPTR) begin
        // Bits above the address width are dropped on purpose.
        dptr <= RIE_FA_W'(strb_merge({20'h00000, dptr}, s_axi_wdata, s_axi_wstrb));
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************

  // Address and data are taken together and only while idle; a busy block stalls the master.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RIE_RESP_OKAY;
    end else begin
      if (wr_en) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(s_axi_awaddr) ? RIE_RESP_OKAY : RIE_RESP_SLVERR;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid &&
                   state == RIE_IDLE) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************

  // Read mux; the data byte comes from memory one cycle after the pointer addresses it.
  always_comb begin
    rd_word = RIE_WORD_RST;
    if (rd_addr == RIE_OFS_CTRL) begin
      rd_word[RIE_CTRL_EXT] = ext_en;
    end else if (rd_addr == RIE_OFS_BANK) begin
      rd_word[RIE_BANK_W-1:0] = bank_pointer_register;
    end else if (rd_addr == RIE_OFS_WREG) begin
      rd_word[7:0] = wreg;
    end else if (rd_addr == RIE_OFS_STATUS) begin
      rd_word[RIE_ST_C] = flag_c;
      rd_word[RIE_ST_Z] = flag_z;
      rd_word[RIE_ST_N] = flag_n;
      rd_word[RIE_ST_BUSY] = state != RIE_IDLE;
      rd_word[RIE_ST_ILL] = illegal;
    end else if (rd_addr == RIE_OFS_FSR2) begin
      rd_word[RIE_FA_W-1:0] = fsr2;
    end else if (rd_addr == RIE_OFS_INSTR) begin
      rd_word[15:0] = instr;
    end else if (rd_addr == RIE_OFS_DPTR) begin
      rd_word[RIE_FA_W-1:0] = dptr;
    end else if (rd_addr == RIE_OFS_DATA) begin
      rd_word[7:0] = mem_rdata;
    end
  end

  // Reads start only while idle so the memory port is free for the pointer access.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RIE_WORD_RST;
      s_axi_rresp <= RIE_RESP_OKAY;
      rd_stage <= 2'b00;
      rd_addr <= '0;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        rd_addr <= s_axi_araddr;
        rd_stage <= 2'b01;
      end else if (s_axi_arvalid && !s_axi_arready && rd_stage == 2'b00 && !s_axi_rvalid &&
                   state == RIE_IDLE) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_stage == 2'b01) begin
        rd_stage <= 2'b10;
      end else if (rd_stage == 2'b10) begin
        rd_stage <= 2'b00;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= is_mapped(rd_addr) ? RIE_RESP_OKAY : RIE_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  property p_rln_result;  // [RL1]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_PROCESS && instr.op == RIE_OP_RLN && !instr.d |=> ##1
      wreg == {$past(mem_rdata[6:0], 2), $past(mem_rdata[7], 2)};
  endproperty
  a_rln_result: assert property (p_rln_result) else $error("rotate left result wrong");  // [RL1]

  property p_rln_carry;  // [RL1]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_WRITE && instr.op == RIE_OP_RLN |=> flag_c == $past(flag_c) && flag_z == ($past(res) == 8'h00);
  endproperty
  a_rln_carry: assert property (p_rln_carry) else $error("rotate left flags wrong");  // [RL1]

  property p_rrc;  // [RL2]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_PROCESS && instr.op == RIE_OP_RRC |=> ##1
      flag_c == $past(mem_rdata[0], 2) && flag_n == $past(flag_c, 2);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate through carry wrong");  // [RL2]

  property p_dest;  // [RL3]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_WRITE |-> if (instr.d) (mem_req.we && mem_req.wdata == res) else (##1 wreg == $past(res));
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");  // [RL3]

  property p_access;  // [RL4]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_READ && !instr.a && !ext_en |->
      mem_req.addr[7:0] == instr.f && mem_req.addr[11:8] == (instr.f < RIE_ACC_SPLIT ? 4'h0 : RIE_ACC_HI_BANK);
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");  // [RL4]

  property p_banked;  // [RL5]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_READ && instr.a |-> mem_req.addr == {bank_pointer_register, instr.f};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");  // [RL5]

  property p_indexed;  // [RL6]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_READ && ext_en && !instr.a && instr.f <= RIE_ILO_MAX |-> mem_req.addr == fsr2 + {4'h0, instr.f};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed literal address wrong");  // [RL6]

  property p_cycle;  // [RL7]
    @(posedge aclk) disable iff (!aresetn)
    state == RIE_DECODE && legal |=> state == RIE_READ ##1 state == RIE_PROCESS ##1 state == RIE_WRITE ##1
      state == RIE_IDLE;
  endproperty
  a_cycle: assert property (p_cycle) else $error("instruction cycle length wrong");  // [RL7]

endmodule : rie_exec

/* File: testbench/rie_fmodel.sv */
// Behavioural model of the data memory file registers beside the rotate datapath.
module rie_fmodel;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Expected contents.
  // ****************************************************************
  // Expected byte of each file register; the memory itself is not reset, so only written places are compared.
  logic [7:0] mem [0:4095];

  // Record a byte that software or the core has placed in a file register.
  task automatic put(input logic [11:0] adr, input logic [7:0] v);
    mem[adr] = v;
  endtask : put
endmodule : rie_fmodel

/* File: testbench/test_rotate_instruction_exec.sv */
// Self-checking testbench of the rotate instruction execution block.
module test_rotate_instruction_exec import rie_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals, clock and design.
  // ****************************************************************
  logic aclk = 1'b0; // Core clock, 40 MHz.
  logic aresetn = 1'b0; // Synchronous reset, active low.
  logic [RIE_OFS_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf; // All lanes: narrow registers ignore the upper ones.
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_errors = 0; // Mismatches and timeouts.
  int n_checks = 0; // Comparisons made.

  // The clock toggles every half period of 12.5 ns.
  always #12.5 aclk = ~aclk;

  rie_exec #(.DEPTH(4096)) u_rie_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  rie_fmodel u_rie_fmodel ();

  // ****************************************************************
  // Report and comparison tasks.
  // ****************************************************************
  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Compare a data word.
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] adr);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: offset %h read %h, expected %h", $time, adr, got, exp);
    end
  endtask : chk_word

  // Compare a bus response code.
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input logic [7:0] adr);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: offset %h answered %b, expected %b", $time, adr, got, exp);
    end
  endtask : chk_resp

  // One clock edge of a bounded wait; a hang ends the run as a failure.
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      n_errors++;
      $display("Error at %0t: handshake timed out", $time);
      close_out();
    end
  endtask : tick

  // ****************************************************************
  // Bus master tasks.
  // ****************************************************************
  // Address and data are offered together, each dropped at its own ready, bready held until bvalid.
  task automatic axi_wr(input logic [7:0] adr, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= adr;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er, adr);
  endtask : axi_wr

  // The read address is dropped at arready, rready held until rvalid.
  task automatic axi_rd(input logic [7:0] adr, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= adr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_word(s_axi_rdata, ed, adr);
    chk_resp(s_axi_rresp, er, adr);
  endtask : axi_rd

  // Place a byte in data memory through the software pointer and note it in the model.
  task automatic mem_set(input logic [11:0] adr, input logic [7:0] v);
    axi_wr(RIE_OFS_DPTR, {20'h0_0000, adr}, RIE_RESP_OKAY);
    axi_wr(RIE_OFS_DATA, {24'h00_0000, v}, RIE_RESP_OKAY);
    u_rie_fmodel.put(adr, v);
  endtask : mem_set

  // Compare a data memory byte with the model.
  task automatic mem_chk(input logic [11:0] adr);
    axi_wr(RIE_OFS_DPTR, {20'h0_0000, adr}, RIE_RESP_OKAY);
    axi_rd(RIE_OFS_DATA, {24'h00_0000, u_rie_fmodel.mem[adr]}, RIE_RESP_OKAY);
  endtask : mem_chk

  // Run one rotate on a prepared operand and compare W, memory and flags.
  task automatic rot_case(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
                          input logic [11:0] adr, input logic [7:0] v, input logic c, input logic ext);
    logic [7:0] r;
    logic co;
    r = (op == RIE_OP_RLN) ? {v[6:0], v[7]} : {c, v[7:1]};
    co = (op == RIE_OP_RLN) ? c : v[0];
    axi_wr(RIE_OFS_CTRL, {31'h0000_0000, ext}, RIE_RESP_OKAY);
    axi_wr(RIE_OFS_WREG, 32'h0000_0000, RIE_RESP_OKAY);
    axi_wr(RIE_OFS_STATUS, {31'h0000_0000, c}, RIE_RESP_OKAY);
    mem_set(adr, v);
    axi_wr(RIE_OFS_INSTR, {16'h0000, op, d, a, f}, RIE_RESP_OKAY);
    if (d) u_rie_fmodel.put(adr, r);
    axi_rd(RIE_OFS_WREG, {24'h00_0000, d ? 8'h00 : r}, RIE_RESP_OKAY);
    mem_chk(adr);
    axi_rd(RIE_OFS_STATUS, {27'h000_0000, r[7], 1'b0, r == 8'h00, 1'b0, co}, RIE_RESP_OKAY);
  endtask : rot_case

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      axi_rd(8'(i * 4), RIE_WORD_RST, RIE_RESP_OKAY);
    end
    axi_rd(8'h20, 32'h0000_0000, RIE_RESP_SLVERR);
    axi_wr(8'h40, 32'h0000_005a, RIE_RESP_SLVERR);
    axi_rd(RIE_OFS_CTRL, 32'h0000_0000, RIE_RESP_OKAY);
    $display("Test reset values and map done");
    axi_wr(RIE_OFS_BANK, 32'h0000_0002, RIE_RESP_OKAY);
    axi_wr(RIE_OFS_FSR2, 32'h0000_0100, RIE_RESP_OKAY);
    rot_case(RIE_OP_RLN, 1'b1, 1'b1, 8'hab, 12'h2ab, 8'hab, 1'b1, 1'b0);
    rot_case(RIE_OP_RRC, 1'b0, 1'b0, 8'h60, 12'hf60, 8'he6, 1'b0, 1'b0);
    rot_case(RIE_OP_RRC, 1'b1, 1'b0, 8'h10, 12'h110, 8'h01, 1'b1, 1'b1);
    rot_case(RIE_OP_RLN, 1'b0, 1'b0, 8'h5f, 12'h15f, 8'h80, 1'b1, 1'b1);
    rot_case(RIE_OP_RLN, 1'b1, 1'b1, 8'h00, 12'h200, 8'h00, 1'b0, 1'b1);
    rot_case(RIE_OP_RRC, 1'b1, 1'b0, 8'h60, 12'hf60, 8'h81, 1'b0, 1'b1);
    rot_case(RIE_OP_RRC, 1'b0, 1'b1, 8'hff, 12'h2ff, 8'h01, 1'b0, 1'b0);
    $display("Test rotate cases done");
    // A word that is not a rotate leaves flags and memory alone and raises the illegal bit.
    axi_wr(RIE_OFS_INSTR, {16'h0000, 6'h3f, 1'b1, 1'b1, 8'hff}, RIE_RESP_OKAY);
    axi_rd(RIE_OFS_STATUS, 32'h0000_0205, RIE_RESP_OKAY);
    mem_chk(12'h2ff);
    $display("Test illegal word done");
    close_out();
  end
endmodule : test_rotate_instruction_exec
